// ---- rtl/dio_controller.v ----
// Halfword digital I/O controller: host port, busy, interrupts, peripheral strobes
// Overview of operation
// RULE_01 - 16-bit output register and 16 input lines, independent paths each way
// RULE_02 - Halfword write to output number loads all 16 bits into output register
// RULE_03 - Halfword read from input number returns the 16 input lines
// RULE_04 - Byte transfers act as halfword on low byte; upper 8 bits undefined
// RULE_05 - Status query returns byte with busy at bit 4, bit 0 as MSB
// RULE_06 - Command enable set, disable clear: interrupts passed immediately
// RULE_07 - Command disable set, enable clear: interrupts withheld but queued
// RULE_08 - Both bits set: disarm, no delivery, no queueing, pending cleared
// RULE_09 - Input busy clears when peripheral data available; interrupt if enabled
// RULE_10 - Input busy sets when a host halfword read completes
// RULE_11 - Output busy clears when output register ready; interrupt if enabled
// RULE_12 - Output busy sets when a host halfword write completes
// RULE_13 - Build option suppresses busy setting; transfers then interrupt driven
// RULE_14 - Busy sets on power-up and on system initialize
// RULE_15 - No command changes busy; host forces it with a throwaway transfer
// RULE_16 - Host read starts new input cycle, telling peripheral to fetch next
// RULE_17 - Host write starts output cycle, telling peripheral data is ready
// RULE_18 - Interrupts generated whether or not busy setting is inhibited
// RULE_19 - Initialize disarms, clears both data registers, sets busy unless inhibited
// RULE_20 - Output uses even switch number N, input uses N+1
// RULE_21 - Interrupt acknowledge returns device number and current status
// RULE_22 - Host enables interrupts on a direction before forcing busy set
// RULE_23 - Peripheral requests output data with about 1 us pulse
// RULE_24 - After host write, about 1 us output-data-available pulse emitted
// RULE_25 - Peripheral signals input available with about 1 us pulse
// RULE_26 - After host read, about 1 us input-data-received pulse emitted
// RULE_27 - Each direction keeps own busy, interrupt mode and pending state
// RULE_28 - Interrupt queued while disabled is delivered once later enabled
`timescale 1ns/1ps
`include "dio_map.vh"

module dio_controller #(
  parameter INHIBIT_BUSY = 0
) (
  clock,
  rst_b,
  init,
  dev_switch,
  op_valid,
  op,
  op_addr,
  op_wdata,
  op_rdata,
  int_req,
  periph_out_data,
  periph_out_request,
  periph_out_available,
  periph_in_data,
  periph_in_available,
  periph_in_received
);
  input  wire        clock;
  input  wire        rst_b;
  input  wire        init;
  input  wire [7:0]  dev_switch;
  input  wire        op_valid;
  input  wire [2:0]  op;
  input  wire [7:0]  op_addr;
  input  wire [15:0] op_wdata;
  output reg  [15:0] op_rdata;
  output wire        int_req;
  output reg  [15:0] periph_out_data;
  input  wire        periph_out_request;
  output wire        periph_out_available;
  input  wire [15:0] periph_in_data;
  input  wire        periph_in_available;
  output wire        periph_in_received;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Switch bit 0 is ignored so the output number is always even
  wire [7:0] out_number = {dev_switch[7:1], 1'b0};          // RULE_20
  wire [7:0] in_number  = {dev_switch[7:1], 1'b1};          // RULE_20
  wire       hit_out    = op_valid && (op_addr == out_number);
  wire       hit_in     = op_valid && (op_addr == in_number);

  wire wr_half = (op == `OP_WRITE_HALF) || (op == `OP_WRITE_BYTE);  // RULE_04
  wire rd_half = (op == `OP_READ_HALF) || (op == `OP_READ_BYTE);    // RULE_04

  wire host_write = hit_out && wr_half;
  wire host_read  = hit_in && rd_half;
  wire cmd_out    = hit_out && (op == `OP_COMMAND);
  wire cmd_in     = hit_in && (op == `OP_COMMAND);
  wire ack_op     = op_valid && (op == `OP_INT_ACK);
  wire sense_out  = hit_out && (op == `OP_SENSE);
  wire sense_in   = hit_in && (op == `OP_SENSE);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [1:0] decode_mode;
    input [7:0] cmd;
    begin
      if (cmd[`CMD_ENABLE_BIT] && cmd[`CMD_DISABLE_BIT]) begin
        decode_mode = `MODE_DISARM;                          // RULE_08
      end else if (cmd[`CMD_ENABLE_BIT]) begin
        decode_mode = `MODE_ENABLE;                          // RULE_06
      end else if (cmd[`CMD_DISABLE_BIT]) begin
        decode_mode = `MODE_DISABLE;                         // RULE_07
      end else begin
        decode_mode = 2'h3;
      end
    end
  endfunction

  function [7:0] status_byte;
    input busy;
    begin
      status_byte = 8'h00;
      status_byte[`STAT_BUSY_BIT] = busy;                    // RULE_05
    end
  endfunction

  // ----------------------------------------------------------------
  // Per-direction state
  // ----------------------------------------------------------------
  reg        out_busy_reg,    out_busy_next;
  reg        in_busy_reg,     in_busy_next;
  reg [1:0]  out_mode_reg,    out_mode_next;
  reg [1:0]  in_mode_reg,     in_mode_next;
  reg        out_pend_reg,    out_pend_next;
  reg        in_pend_reg,     in_pend_next;
  // The output word and the answer word live in the output ports
  reg [15:0] out_data_next;
  reg [15:0] rdata_next;
  reg        in_avail_d_reg;
  reg        out_req_d_reg;

  // ----------------------------------------------------------------
  // Peripheral events
  // ----------------------------------------------------------------
  // Edge detection keeps a 1 us peripheral pulse to one event
  // A pulse held high through reset counts as a fresh event on release
  wire in_event  = periph_in_available && !in_avail_d_reg;   // RULE_25
  wire out_event = periph_out_request && !out_req_d_reg;     // RULE_23

  wire set_busy_ok = (INHIBIT_BUSY == 0);                    // RULE_13

  // ----------------------------------------------------------------
  // Interrupt request and acknowledge
  // ----------------------------------------------------------------
  // Non-delivered (queued) interrupts do not drive the request line
  assign int_req = (out_pend_reg && out_mode_reg == `MODE_ENABLE)
                || (in_pend_reg && in_mode_reg == `MODE_ENABLE);  // RULE_28

  // Acknowledge picks the output side first when both are asking
  wire ack_out = ack_op && out_pend_reg && out_mode_reg == `MODE_ENABLE;
  wire ack_in  = ack_op && !ack_out && in_pend_reg && in_mode_reg == `MODE_ENABLE;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Order of the blocks below sets priority: later assignments win
  always @* begin
    out_busy_next = out_busy_reg;
    in_busy_next  = in_busy_reg;
    out_mode_next = out_mode_reg;
    in_mode_next  = in_mode_reg;
    out_pend_next = out_pend_reg;
    in_pend_next  = in_pend_reg;
    out_data_next = periph_out_data;
    rdata_next    = op_rdata;

    if (init) begin
      out_mode_next = `MODE_DISARM;                          // RULE_19
      in_mode_next  = `MODE_DISARM;                          // RULE_19
      out_pend_next = 1'b0;
      in_pend_next  = 1'b0;
      out_data_next = `DATA_RESET;                           // RULE_19
      rdata_next    = `DATA_RESET;                           // RULE_19
      out_busy_next = set_busy_ok;                           // RULE_14
      in_busy_next  = set_busy_ok;                           // RULE_14
    end else begin
      // Commands touch mode and pending only, never busy
      if (cmd_out && decode_mode(op_wdata[7:0]) != 2'h3) begin
        out_mode_next = decode_mode(op_wdata[7:0]);          // RULE_15
      end
      if (cmd_in && decode_mode(op_wdata[7:0]) != 2'h3) begin
        in_mode_next = decode_mode(op_wdata[7:0]);           // RULE_27
      end
      if (ack_out) begin
        out_pend_next = 1'b0;
      end
      if (ack_in) begin
        in_pend_next = 1'b0;
      end

      // A throwaway transfer is the only way to force busy set
      if (host_write) begin
        out_data_next = op_wdata;                            // RULE_02
        if (set_busy_ok) begin
          out_busy_next = 1'b1;                              // RULE_12
        end
      end
      if (host_read) begin
        rdata_next = periph_in_data;                         // RULE_03
        if (set_busy_ok) begin
          in_busy_next = 1'b1;                               // RULE_10
        end
      end
      // Sense reports the addressed side only and disturbs nothing
      if (sense_out) begin
        rdata_next = {8'h00, status_byte(out_busy_reg)};     // RULE_05
      end
      if (sense_in) begin
        rdata_next = {8'h00, status_byte(in_busy_reg)};      // RULE_05
      end
      // An unclaimed acknowledge answers zero, never a stale number
      if (ack_out) begin
        rdata_next = {out_number, status_byte(out_busy_reg)};  // RULE_21
      end else if (ack_in) begin
        rdata_next = {in_number, status_byte(in_busy_reg)};    // RULE_21
      end else if (ack_op) begin
        rdata_next = 16'h0000;
      end

      // Peripheral events win over a same-cycle acknowledge or busy set
      if (out_event) begin
        out_busy_next = 1'b0;                                // RULE_11
        if (out_mode_next != `MODE_DISARM) begin
          out_pend_next = 1'b1;                              // RULE_18
        end
      end
      if (in_event) begin
        in_busy_next = 1'b0;                                 // RULE_09
        if (in_mode_next != `MODE_DISARM) begin
          in_pend_next = 1'b1;                               // RULE_18
        end
      end

      // Disarm clears queued work even against a fresh event
      if (out_mode_next == `MODE_DISARM) begin
        out_pend_next = 1'b0;                                // RULE_08
      end
      if (in_mode_next == `MODE_DISARM) begin
        in_pend_next = 1'b0;                                 // RULE_08
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Power-up leaves both sides busy, even with INHIBIT_BUSY set
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_busy_reg    <= 1'b1;
      in_busy_reg     <= 1'b1;
      out_mode_reg    <= `MODE_DISARM;
      in_mode_reg     <= `MODE_DISARM;
      out_pend_reg    <= 1'b0;
      in_pend_reg     <= 1'b0;
      periph_out_data <= `DATA_RESET;
      op_rdata        <= `DATA_RESET;
      in_avail_d_reg  <= 1'b0;
      out_req_d_reg   <= 1'b0;
    end else begin
      out_busy_reg    <= out_busy_next;
      in_busy_reg     <= in_busy_next;
      out_mode_reg    <= out_mode_next;
      in_mode_reg     <= in_mode_next;
      out_pend_reg    <= out_pend_next;
      in_pend_reg     <= in_pend_next;
      periph_out_data <= out_data_next;                      // RULE_01
      op_rdata        <= rdata_next;
      in_avail_d_reg  <= periph_in_available;
      out_req_d_reg   <= periph_out_request;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral strobes
  // ----------------------------------------------------------------
  // Start a cycle after the write so the data is already settled
  reg write_d_reg;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      write_d_reg <= 1'b0;
    end else begin
      write_d_reg <= host_write && !init;
    end
  end

  // Initialize cuts a running strobe short
  dio_pulse_gen out_strobe (
    .clock (clock),
    .rst_b (rst_b),
    .init  (init),
    .start (write_d_reg),                                    // RULE_17
    .pulse (periph_out_available)                            // RULE_24
  );

  // The read strobe starts at once: the word is already taken
  dio_pulse_gen in_strobe (
    .clock (clock),
    .rst_b (rst_b),
    .init  (init),
    .start (host_read && !init),                             // RULE_16
    .pulse (periph_in_received)                              // RULE_26
  );

endmodule // dio_controller

// ---- rtl/dio_map.vh ----
// Constants for the halfword digital I/O controller
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// Status byte counts bit 0 as the MSB, so busy (bit 4) is vector bit 3
`define STAT_BUSY_BIT      3
// Command byte: disable (bit 0) is vector bit 7, enable (bit 1) is vector bit 6
`define CMD_DISABLE_BIT    7
`define CMD_ENABLE_BIT     6

// Host operation codes on op
`define OP_NONE            3'h0
`define OP_SENSE           3'h1
`define OP_COMMAND         3'h2
`define OP_WRITE_HALF      3'h3
`define OP_READ_HALF       3'h4
`define OP_WRITE_BYTE      3'h5
`define OP_READ_BYTE       3'h6
`define OP_INT_ACK         3'h7

// Interrupt modes
`define MODE_DISARM        2'h0
`define MODE_ENABLE        2'h1
`define MODE_DISABLE       2'h2

// Reset values
`define DATA_RESET         16'h0000

// Peripheral pulse width: about 1 us at the 10 ns clock
`define PULSE_CYCLES       7'h64
`define PULSE_CNT_W        7

`endif

// ---- rtl/dio_pulse_gen.v ----
// One-shot that stretches a start strobe into a fixed-width strobe
`timescale 1ns/1ps
`include "dio_map.vh"

module dio_pulse_gen (
  clock,
  rst_b,
  init,
  start,
  pulse
);
  input  wire clock;
  input  wire rst_b;
  input  wire init;
  input  wire start;
  output wire pulse;

  reg [`PULSE_CNT_W-1:0] count_reg;
  reg [`PULSE_CNT_W-1:0] count_next;

  localparam [`PULSE_CNT_W-1:0] WIDTH = `PULSE_CYCLES;

  assign pulse = (count_reg != {`PULSE_CNT_W{1'b0}});

  always @* begin
    count_next = count_reg;
    if (init) begin
      count_next = {`PULSE_CNT_W{1'b0}};
    end else if (start) begin
      // A restart mid-pulse stretches it rather than dropping it
      count_next = WIDTH;
    end else if (pulse) begin
      count_next = count_reg - 1'b1;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= {`PULSE_CNT_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // dio_pulse_gen

// ---- tb/dio_controller_checker.sv ----
// Port checker for the halfword digital I/O controller
`timescale 1ns/1ps
`include "dio_map.vh"

module dio_controller_checker (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        init,
  input wire logic [7:0]  dev_switch,
  input wire logic        op_valid,
  input wire logic [2:0]  op,
  input wire logic [7:0]  op_addr,
  input wire logic [15:0] op_wdata,
  input wire logic [15:0] op_rdata,
  input wire logic        int_req,
  input wire logic [15:0] periph_out_data,
  input wire logic        periph_out_request,
  input wire logic        periph_out_available,
  input wire logic [15:0] periph_in_data,
  input wire logic        periph_in_available,
  input wire logic        periph_in_received
);
  logic [7:0] cnt_reg;
  logic       in_prev_reg;
  logic       req_prev_reg;
  wire        hit_out = op_valid && op_addr == {dev_switch[7:1], 1'b0};
  wire        hit_in  = op_valid && op_addr == {dev_switch[7:1], 1'b1};
  wire        wr      = hit_out && op == `OP_WRITE_HALF;
  wire        rd      = hit_in && op == `OP_READ_HALF;
  wire        ev      = periph_in_available && !in_prev_reg || periph_out_request && !req_prev_reg;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg      <= 8'h00;
      in_prev_reg  <= 1'b0;
      req_prev_reg <= 1'b0;
    end else begin
      cnt_reg      <= periph_out_available ? cnt_reg + 8'h01 : 8'h00;
      in_prev_reg  <= periph_in_available;
      req_prev_reg <= periph_out_request;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b || init);

  property p_wr_load; wr |=> periph_out_data == $past(op_wdata); endproperty
  a_wr_load: assert property (p_wr_load) else $error("output word not loaded");
  property p_rd_data; rd |=> op_rdata == $past(periph_in_data); endproperty
  a_rd_data: assert property (p_rd_data) else $error("input word wrong");
  property p_out_strobe; wr |-> ##2 periph_out_available; endproperty
  a_out_strobe: assert property (p_out_strobe) else $error("no output strobe");
  property p_in_strobe; rd |=> periph_in_received; endproperty
  a_in_strobe: assert property (p_in_strobe) else $error("no input strobe");
  property p_out_width; $fell(periph_out_available) |-> cnt_reg == 8'h64; endproperty
  a_out_width: assert property (p_out_width) else $error("strobe width wrong");
  property p_int_cause; $rose(int_req) |-> $past(ev || op_valid && op == `OP_COMMAND); endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
  property p_ack_num; op_valid && op == `OP_INT_ACK && int_req |=> op_rdata[15:9] == dev_switch[7:1]; endproperty
  a_ack_num: assert property (p_ack_num) else $error("ack number wrong");
  property p_ignore;
    op_valid && op_addr[7:1] != dev_switch[7:1] && op != `OP_INT_ACK
      |=> $stable(op_rdata) && $stable(periph_out_data);
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign number answered");

  c_write: cover property (wr);
  c_int: cover property ($rose(int_req));
  c_ack: cover property (op_valid && op == `OP_INT_ACK && int_req);
endmodule // dio_controller_checker

bind dio_controller dio_controller_checker u_chk (.*);

// ---- tb/periph_model.sv ----
// Peripheral model: input word lines and request/available strobes
`timescale 1ns/1ps

module periph_model (
  input  wire logic        clock,
  input  wire logic        periph_in_received,
  output var  logic [15:0] periph_in_data,
  output var  logic        periph_in_available,
  output var  logic        periph_out_request
);
  initial begin
    periph_in_data      = 16'h0000;
    periph_in_available = 1'b0;
    periph_out_request  = 1'b0;
  end

  // Once taken, the lines stop showing the old word
  always @(posedge periph_in_received) periph_in_data <= ~periph_in_data;

  task automatic strobe(input logic dir_in, input logic [15:0] w, input int len);
    @(negedge clock);
    if (dir_in) begin
      periph_in_data      = w;
      periph_in_available = 1'b1;
    end else begin
      periph_out_request  = 1'b1;
    end
    repeat (len) @(negedge clock);
    periph_in_available = 1'b0;
    periph_out_request  = 1'b0;
  endtask
endmodule // periph_model

// ---- tb/tb.sv ----
// Self-checking bench for the halfword digital I/O controller
`timescale 1ns/1ps
`include "dio_map.vh"

module tb;
  logic        clock      = 1'b0;
  logic        rst_b      = 1'b0;
  logic        init       = 1'b0;
  logic [7:0]  dev_switch = 8'h00;
  logic        op_valid   = 1'b0;
  logic [2:0]  op         = `OP_NONE;
  logic [7:0]  op_addr    = 8'h00;
  logic [15:0] op_wdata   = 16'h0000;
  wire  [15:0] op_rdata, periph_out_data, periph_in_data;
  wire         int_req, periph_out_request, periph_out_available;
  wire         periph_in_available, periph_in_received;
  integer      seed       = 60628;
  integer      bad_count  = 0;
  integer      checked    = 0;
  logic        due        = 1'b0;
  logic [7:0]  n;
  logic [15:0] w;
  logic [15:0] exp_q[$];
  string       nm_q[$];

  always #5 clock = ~clock;

  dio_controller u_dut (.clock(clock), .rst_b(rst_b), .init(init), .dev_switch(dev_switch),
    .op_valid(op_valid), .op(op), .op_addr(op_addr), .op_wdata(op_wdata), .op_rdata(op_rdata),
    .int_req(int_req), .periph_out_data(periph_out_data),
    .periph_out_request(periph_out_request), .periph_out_available(periph_out_available),
    .periph_in_data(periph_in_data), .periph_in_available(periph_in_available),
    .periph_in_received(periph_in_received));
  periph_model u_per (.clock(clock), .periph_in_received(periph_in_received),
    .periph_in_data(periph_in_data), .periph_in_available(periph_in_available),
    .periph_out_request(periph_out_request));

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task do_op(input logic [2:0] o, input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    op_valid = 1'b1;
    op       = o;
    op_addr  = a;
    op_wdata = d;
    @(negedge clock);
    op_valid = 1'b0;
  endtask

  task ask(input logic [2:0] o, input logic [7:0] a, input logic [15:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    do_op(o, a, 16'h0000);
  endtask

  task results;
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Answers land on the taking edge and are checked at the next falling edge
  always @(posedge clock) due <= op_valid && (op == `OP_INT_ACK || op_addr[7:1] == n[7:1]
    && (op == `OP_SENSE || op == `OP_READ_HALF));
  always @(negedge clock) if (due) chk(nm_q.pop_front(), op_rdata, exp_q.pop_front());

  initial begin
    #100000;
    bad_count = bad_count + 1;
    results;
  end

  initial begin
    dev_switch = 8'($random(seed));
    n = {dev_switch[7:1], 1'b0};
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    ask(`OP_SENSE, n, 16'h0008, "out_status");
    ask(`OP_SENSE, n + 8'h01, 16'h0008, "in_status");
    chk("out_data", periph_out_data, 16'h0000);
    do_op(`OP_COMMAND, n, 16'h0040);
    w = 16'($random(seed));
    do_op(`OP_WRITE_HALF, n, w);
    do_op(`OP_WRITE_HALF, n + 8'h01, ~w);
    do_op(`OP_WRITE_HALF, n ^ 8'h10, ~w);
    chk("out_data", periph_out_data, w);
    ask(`OP_SENSE, n, 16'h0008, "out_status");
    u_per.strobe(1'b0, 16'h0000, 100);
    chk("int_req", {15'h0000, int_req}, 16'h0001);
    ask(`OP_SENSE, n, 16'h0000, "out_status");
    ask(`OP_INT_ACK, 8'h00, {n, 8'h00}, "ack");
    chk("int_req", {15'h0000, int_req}, 16'h0000);
    w = 16'($random(seed));
    do_op(`OP_COMMAND, n + 8'h01, 16'h0080);
    u_per.strobe(1'b1, w, 60);
    chk("int_req", {15'h0000, int_req}, 16'h0000);
    ask(`OP_SENSE, n + 8'h01, 16'h0000, "in_status");
    do_op(`OP_COMMAND, n + 8'h01, 16'h0040);
    chk("int_req", {15'h0000, int_req}, 16'h0001);
    ask(`OP_READ_HALF, n + 8'h01, w, "in_data");
    ask(`OP_SENSE, n + 8'h01, 16'h0008, "in_status");
    do_op(`OP_COMMAND, n + 8'h01, 16'h00C0);
    chk("int_req", {15'h0000, int_req}, 16'h0000);
    // Lines now show the inverse of w, since the model saw the read strobe
    do_op(`OP_READ_BYTE, n + 8'h01, 16'h0000);
    chk("in_low", {8'h00, op_rdata[7:0]}, {8'h00, ~w[7:0]});
    w = 16'($random(seed));
    do_op(`OP_WRITE_BYTE, n, w);
    chk("out_low", {8'h00, periph_out_data[7:0]}, {8'h00, w[7:0]});
    u_per.strobe(1'b1, ~w, 100);
    repeat (10) @(negedge clock);
    ask(`OP_SENSE, n, 16'h0008, "out_status");
    init = 1'b1;
    @(negedge clock);
    init = 1'b0;
    chk("rdata", op_rdata, 16'h0000);
    chk("out_data", periph_out_data, 16'h0000);
    ask(`OP_SENSE, n + 8'h01, 16'h0008, "in_status");
    u_per.strobe(1'b0, 16'h0000, 100);
    chk("int_req", {15'h0000, int_req}, 16'h0000);
    @(negedge clock);
    results;
  end
endmodule // tb
